// ---- common/stream_pipe_regs.svh ----
/*
 * constants for the host OUT stream pipe setup machine.
 * assumes it is included by bare name from design and bench files.
 */
`ifndef STREAM_PIPE_REGS_SVH
`define STREAM_PIPE_REGS_SVH

`define SID_W           16
`define SID_PRIME       16'hfffe
`define SID_NO_STREAM   16'h0000
`define NUMP_W          5
`define RETRY_W         2
`define RETRY_MAX       2'h3

`endif

// ---- common/stream_pipe_pkg.sv ----
/*
 * types for the host OUT stream pipe setup machine.
 * assumes stream_pipe_regs.svh is on the include path.
 */
`include "stream_pipe_regs.svh"

package stream_pipe_pkg;
   typedef logic [`SID_W-1:0]  sid_t;
   typedef logic [`NUMP_W-1:0] nump_t;

   typedef enum logic [2:0] {
      ST_DISABLED   = 3'b000,
      ST_PRIME      = 3'b001,
      ST_IDLE       = 3'b010,
      ST_START      = 3'b011,
      ST_START_END  = 3'b100,
      ST_MOVE_DATA  = 3'b101,
      ST_HALTED     = 3'b110
   } pipe_state_e;
endpackage

// ---- verilog/pipe_retry_count.sv ----
/*
 * retry counter for zero-length setup packets (prime and reject).
 * assumes the owner holds i_clear outside a wait and pulses i_retry per resend.
 */
`timescale 1ns/100ps
`default_nettype none
`include "stream_pipe_regs.svh"

module pipe_retry_count (
   // clock and reset
   input  wire logic i_clk,
   input  wire logic i_sys_rst,
   // control
   input  wire logic i_clear,
   input  wire logic i_retry,
   // status
   output logic      o_exhausted
);
   logic [`RETRY_W-1:0] count_q;

   always_ff @(posedge i_clk or posedge i_sys_rst) begin
      if (i_sys_rst) begin
         count_q <= '0;
      end else if (i_clear) begin
         count_q <= '0;
      end else if (i_retry && count_q != `RETRY_MAX) begin
         count_q <= count_q + 2'h1;
      end
   end

   assign o_exhausted = (count_q == `RETRY_MAX) && i_retry;
endmodule

`default_nettype wire

// ---- verilog/host_out_stream_pipe_setup_fsm.sv ----
/*
 * host OUT bulk stream pipe: disabled, prime pipe, idle, start stream phases.
 * assumes received packets arrive as one-cycle decoded pulses on i_clk, and
 * that the move data machine reports back by pulse on i_move_done.
 */
`timescale 1ns/100ps
`default_nettype none

`include "stream_pipe_regs.svh"

// Operation
// - configure or halt request disables pipe, last selected stream becomes none.
// - from disabled, software data sends zero-length prime packet, enters prime.
// - host may resend prime; stays until prime nrdy; exhausted retries halt.
// - prime nrdy in prime pipe moves to idle.
// - deferred data header in prime pipe moves to idle, no payload follows.
// - erdy in prime pipe is a crossing; stay and wait for nrdy.
// - first idle after disabled never starts a host-chosen stream.
// - idle erdy with nonzero count goes to start stream, records stream.
// - idle software post chooses prime or host move by local policy.
// - prime choice sends zero-length prime packet, enters prime pipe.
// - move choice sends first payload of x, current becomes x.
// - pending flag set when more than one max packet is waiting.
// - host-initiated move is optional and can be switched off.
// - accepting proposal sends first payload of n, current becomes n.
// - proposal is accepted whenever data exists for that stream.
// - no data rejects with zero-length no-stream packet, enters start end.
// - no-stream nrdy in start end returns to idle.
module host_out_stream_pipe_setup_fsm (
   // clock and reset
   input  wire logic                   i_clk,
   input  wire logic                   i_sys_rst,
   // endpoint control
   input  wire logic                   i_ep_config,
   input  wire logic                   i_ep_halt_req,
   input  wire logic                   i_move_enable,
   // software posting
   input  wire logic                   i_sw_post,
   input  wire stream_pipe_pkg::sid_t  i_sw_stream,
   input  wire logic                   i_sw_multi_pkt,
   // endpoint data lookup for proposed stream
   output logic                        o_query_valid,
   output stream_pipe_pkg::sid_t       o_query_stream,
   input  wire logic                   i_query_has_data,
   input  wire logic                   i_query_multi_pkt,
   // received packets
   input  wire logic                   i_rx_nrdy,
   input  wire logic                   i_rx_erdy,
   input  wire logic                   i_rx_ack_retry,
   input  wire logic                   i_rx_dph_deferred,
   input  wire stream_pipe_pkg::sid_t  i_rx_stream,
   input  wire stream_pipe_pkg::nump_t i_rx_nump,
   // move data hand back
   input  wire logic                   i_move_done,
   // transmit request
   output logic                        o_tx_dp,
   output stream_pipe_pkg::sid_t       o_tx_stream,
   output logic                        o_tx_pp,
   output logic                        o_tx_zero_len,
   // pipe status
   output stream_pipe_pkg::pipe_state_e o_state,
   output stream_pipe_pkg::sid_t       o_current_stream,
   output stream_pipe_pkg::sid_t       o_last_selected_stream,
   output logic                        o_pipe_halted,
   output logic                        o_move_start
);
   import stream_pipe_pkg::*;

   pipe_state_e state_q;
   sid_t        last_selected_stream_q;
   sid_t        current_stream_q;
   sid_t        proposed_q;
   logic        first_idle_q;
   logic        tx_dp_q;
   sid_t        tx_stream_q;
   logic        tx_pp_q;
   logic        tx_zero_q;
   logic        query_q;
   logic        move_start_q;
   logic        halted_q;
   logic        retry_clear;
   logic        retry_fire;
   logic        retry_out;
   logic        choose_move;
   logic        wait_zero_ack;

   function automatic logic sid_is(input sid_t a, input sid_t b);
      sid_is = (a == b);
   endfunction

   wire logic ep_reset = i_ep_config | i_ep_halt_req;

   // move only when enabled, allowed past first idle, and stream matches
   assign choose_move = i_move_enable && !first_idle_q
                        && sid_is(i_sw_stream, last_selected_stream_q);

   assign wait_zero_ack = (state_q == ST_PRIME || state_q == ST_START_END);
   assign retry_fire    = wait_zero_ack && i_rx_ack_retry;
   assign retry_clear   = !wait_zero_ack;   // fresh count for each prime or reject wait

   pipe_retry_count u_retry (
      .i_clk       (i_clk),
      .i_sys_rst   (i_sys_rst),
      .i_clear     (retry_clear),
      .i_retry     (retry_fire),
      .o_exhausted (retry_out)
   );

   // pipe state
   always_ff @(posedge i_clk or posedge i_sys_rst) begin
      if (i_sys_rst) begin
         state_q  <= ST_DISABLED;
         halted_q <= 1'b0;
      end else if (ep_reset) begin
         state_q  <= ST_DISABLED;
         halted_q <= 1'b0;
      end else if (retry_out) begin
         state_q  <= ST_HALTED;
         halted_q <= 1'b1;
      end else begin
         case (state_q)
            ST_DISABLED: begin
               if (i_sw_post) begin
                  state_q <= ST_PRIME;
               end
            end
            ST_PRIME: begin
               if (i_rx_nrdy && sid_is(i_rx_stream, `SID_PRIME)) begin
                  state_q <= ST_IDLE;
               end else if (i_rx_dph_deferred) begin
                  state_q <= ST_IDLE;
               end
               // erdy here is a crossing and is ignored
            end
            ST_IDLE: begin
               if (i_rx_erdy && i_rx_nump != '0) begin
                  state_q <= ST_START;
               end else if (i_sw_post) begin
                  state_q <= choose_move ? ST_MOVE_DATA : ST_PRIME;
               end
            end
            ST_START: begin
               if (query_q) begin
                  state_q <= i_query_has_data ? ST_MOVE_DATA
                                              : ST_START_END;
               end
            end
            ST_START_END: begin
               if (i_rx_nrdy && sid_is(i_rx_stream, `SID_NO_STREAM)) begin
                  state_q <= ST_IDLE;
               end else if (i_rx_dph_deferred) begin
                  state_q <= ST_IDLE;
               end
            end
            ST_MOVE_DATA: begin
               if (i_move_done) begin
                  state_q <= ST_IDLE;
               end
            end
            ST_HALTED: begin
               state_q <= ST_HALTED;
            end
            default: begin
               state_q <= ST_DISABLED;
            end
         endcase
      end
   end

   // first idle after disabled blocks host move
   always_ff @(posedge i_clk or posedge i_sys_rst) begin
      if (i_sys_rst) begin
         first_idle_q <= 1'b1;
      end else if (ep_reset || state_q == ST_DISABLED) begin
         first_idle_q <= 1'b1;
      end else if (state_q == ST_IDLE && (i_rx_erdy || i_sw_post)) begin
         first_idle_q <= 1'b0;
      end
   end

   // stream variables
   always_ff @(posedge i_clk or posedge i_sys_rst) begin
      if (i_sys_rst) begin
         last_selected_stream_q <= `SID_NO_STREAM;
         current_stream_q       <= `SID_NO_STREAM;
         proposed_q             <= `SID_NO_STREAM;
      end else if (ep_reset) begin
         last_selected_stream_q <= `SID_NO_STREAM;
      end else if (state_q == ST_IDLE && i_rx_erdy && i_rx_nump != '0) begin
         last_selected_stream_q <= i_rx_stream;
         proposed_q             <= i_rx_stream;
      end else if (state_q == ST_IDLE && i_sw_post && choose_move) begin
         current_stream_q <= i_sw_stream;
      end else if (state_q == ST_START && query_q && i_query_has_data) begin
         current_stream_q <= proposed_q;
      end
   end

   // endpoint data lookup for a proposal, in the same cycle as entering start
   always_ff @(posedge i_clk or posedge i_sys_rst) begin
      if (i_sys_rst) begin
         query_q <= 1'b0;
      end else begin
         query_q <= !ep_reset && state_q == ST_IDLE && i_rx_erdy && i_rx_nump != '0;
      end
   end

   // transmit requests
   always_ff @(posedge i_clk or posedge i_sys_rst) begin
      if (i_sys_rst) begin
         tx_dp_q      <= 1'b0;
         tx_stream_q  <= `SID_NO_STREAM;
         tx_pp_q      <= 1'b0;
         tx_zero_q    <= 1'b0;
         move_start_q <= 1'b0;
      end else begin
         tx_dp_q      <= 1'b0;
         move_start_q <= 1'b0;
         if (ep_reset) begin
            tx_dp_q <= 1'b0;
         end else if (state_q == ST_DISABLED && i_sw_post) begin
            tx_dp_q     <= 1'b1;
            tx_stream_q <= `SID_PRIME;
            tx_pp_q     <= 1'b0;
            tx_zero_q   <= 1'b1;
         end else if (retry_fire && !retry_out) begin
            tx_dp_q <= 1'b1;
         end else if (state_q == ST_IDLE && !(i_rx_erdy && i_rx_nump != '0)
                      && i_sw_post) begin
            tx_dp_q      <= 1'b1;
            tx_stream_q  <= choose_move ? i_sw_stream : `SID_PRIME;
            tx_pp_q      <= choose_move && i_sw_multi_pkt;
            tx_zero_q    <= !choose_move;
            move_start_q <= choose_move;
         end else if (state_q == ST_START && query_q) begin
            tx_dp_q      <= 1'b1;
            tx_stream_q  <= i_query_has_data ? proposed_q : `SID_NO_STREAM;
            tx_pp_q      <= i_query_has_data && i_query_multi_pkt;
            tx_zero_q    <= !i_query_has_data;
            move_start_q <= i_query_has_data;
         end
      end
   end

   assign o_state                = state_q;
   assign o_current_stream       = current_stream_q;
   assign o_last_selected_stream = last_selected_stream_q;
   assign o_pipe_halted          = halted_q;
   assign o_tx_dp                = tx_dp_q;
   assign o_tx_stream            = tx_stream_q;
   assign o_tx_pp                = tx_pp_q;
   assign o_tx_zero_len          = tx_zero_q;
   assign o_query_valid          = query_q;
   assign o_query_stream         = proposed_q;
   assign o_move_start           = move_start_q;

   halt_clears_a: assert property (@(posedge i_clk) disable iff (i_sys_rst)
      ep_reset |=> state_q == ST_DISABLED && last_selected_stream_q == `SID_NO_STREAM)
      else $error("endpoint reset did not disable pipe");
   prime_send_a: assert property (@(posedge i_clk) disable iff (i_sys_rst)
      state_q == ST_DISABLED && i_sw_post && !ep_reset |=> state_q == ST_PRIME
      && tx_dp_q && tx_stream_q == `SID_PRIME && !tx_pp_q && tx_zero_q)
      else $error("disabled post did not prime");
   prime_nrdy_a: assert property (@(posedge i_clk) disable iff (i_sys_rst)
      state_q == ST_PRIME && !ep_reset && !retry_out && i_rx_nrdy
      && i_rx_stream == `SID_PRIME |=> state_q == ST_IDLE)
      else $error("prime nrdy did not reach idle");
   prime_defer_a: assert property (@(posedge i_clk) disable iff (i_sys_rst)
      state_q == ST_PRIME && !ep_reset && !retry_out && i_rx_dph_deferred |=> state_q == ST_IDLE)
      else $error("deferred header did not reach idle");
   prime_race_a: assert property (@(posedge i_clk) disable iff (i_sys_rst)
      state_q == ST_PRIME && i_rx_erdy && !i_rx_nrdy && !i_rx_dph_deferred
      && !ep_reset && !retry_out |=> state_q == ST_PRIME)
      else $error("erdy left prime pipe");
   erdy_select_a: assert property (@(posedge i_clk) disable iff (i_sys_rst)
      state_q == ST_IDLE && !ep_reset && i_rx_erdy && i_rx_nump != '0 |=>
      state_q == ST_START && last_selected_stream_q == $past(i_rx_stream))
      else $error("erdy did not start stream");
   first_idle_a: assert property (@(posedge i_clk) disable iff (i_sys_rst)
      move_start_q && $past(state_q) == ST_IDLE |-> !$past(first_idle_q))
      else $error("host move on first idle");
   accept_a: assert property (@(posedge i_clk) disable iff (i_sys_rst)
      state_q == ST_START && query_q && i_query_has_data && !ep_reset |=>
      state_q == ST_MOVE_DATA && tx_stream_q == current_stream_q && !tx_zero_q)
      else $error("proposal not accepted");
   reject_a: assert property (@(posedge i_clk) disable iff (i_sys_rst)
      state_q == ST_START && query_q && !i_query_has_data && !ep_reset |=>
      state_q == ST_START_END && tx_stream_q == `SID_NO_STREAM && !tx_pp_q)
      else $error("proposal not rejected");
   end_nrdy_a: assert property (@(posedge i_clk) disable iff (i_sys_rst)
      state_q == ST_START_END && !ep_reset && !retry_out && i_rx_nrdy
      && i_rx_stream == `SID_NO_STREAM |=> state_q == ST_IDLE)
      else $error("no-stream nrdy did not reach idle");

   prime_done_c: cover property (@(posedge i_clk) state_q == ST_PRIME ##1 state_q == ST_IDLE);
   start_move_c: cover property (@(posedge i_clk) state_q == ST_START ##1 state_q == ST_MOVE_DATA);
   host_move_c:  cover property (@(posedge i_clk) state_q == ST_IDLE ##1 state_q == ST_MOVE_DATA);
   halt_c:       cover property (@(posedge i_clk) state_q == ST_HALTED);
endmodule

`default_nettype wire

// ---- dv/peer_stream_ep.sv ----
/*
 * peripheral OUT stream endpoint model answering zero-length setup packets.
 * assumes host outputs are settled at the falling clock edge.
 */
`timescale 1ns/100ps
`default_nettype none

module peer_stream_ep (
   // host send
   input  wire logic                   i_clk,
   input  wire logic                   i_tx_dp,
   input  wire logic                   i_tx_zero_len,
   input  wire stream_pipe_pkg::sid_t  i_tx_stream,
   // scenario controls
   input  wire logic [2:0]             i_nbad,
   input  wire logic                   i_defer,
   input  wire logic                   i_erdy_req,
   input  wire stream_pipe_pkg::sid_t  i_erdy_stream,
   // packets to host
   output logic                        o_nrdy,
   output logic                        o_erdy,
   output logic                        o_ack_retry,
   output logic                        o_deferred,
   output stream_pipe_pkg::sid_t       o_stream,
   output stream_pipe_pkg::nump_t      o_nump
);
   import stream_pipe_pkg::*;
   logic       busy_q;
   logic [1:0] wait_q;
   logic [2:0] bad_q;
   sid_t       pend_q;

   initial begin
      {o_nrdy, o_erdy, o_ack_retry, o_deferred, busy_q, wait_q, bad_q} = '0;
      o_stream = '0;
      o_nump = '0;
      pend_q = '0;
   end

   always @(negedge i_clk) begin
      {o_nrdy, o_erdy, o_ack_retry, o_deferred} <= '0;
      // unqualified lines toggle so a stale value never looks valid
      o_stream <= ~o_stream;
      o_nump <= ~o_nump;
      if (i_erdy_req) begin
         o_erdy <= 1'b1;
         o_stream <= i_erdy_stream;
         o_nump <= 5'h02;
      end else if (busy_q && wait_q != 2'h0) begin
         wait_q <= wait_q - 2'h1;
      end else if (busy_q) begin
         busy_q <= 1'b0;
         o_stream <= pend_q;
         if (i_defer) begin
            o_deferred <= 1'b1;
         end else if (bad_q < i_nbad) begin
            o_ack_retry <= 1'b1;
            o_nump <= 5'h01;
            if (i_nbad != 3'h7) bad_q <= bad_q + 3'h1;
         end else begin
            o_nrdy <= 1'b1;
            bad_q <= '0;
         end
      end
      if (i_tx_dp && i_tx_zero_len) begin
         busy_q <= 1'b1;
         wait_q <= 2'h2;
         pend_q <= i_tx_stream;
      end
   end
endmodule

`default_nettype wire

// ---- dv/test_host_out_stream_pipe_setup_fsm.sv ----
/*
 * self-checking bench for the host OUT stream pipe setup machine.
 * assumes the peripheral model drives all received-packet inputs.
 */
`timescale 1ns/100ps
`default_nettype none
`include "stream_pipe_regs.svh"

module test_host_out_stream_pipe_setup_fsm;
   import stream_pipe_pkg::*;
   logic clk = 0, rst = 1, cfg = 0, halt = 0, men = 1, post = 0, smulti = 0;
   logic has = 0, qmulti = 0, done = 0, erq = 0, defer = 0;
   logic [2:0] nbad = 0;
   sid_t sstr = '0, estr = '0;
   wire logic nrdy, erdy, aretry, dfr, txdp, txpp, txz, qv, halted, mstart;
   wire sid_t rstr, txs, qs, cur, last;
   wire nump_t rnump;
   wire pipe_state_e st;
   int err_count = 0, n_tests = 0;

   always #12.5 clk = ~clk;

   host_out_stream_pipe_setup_fsm i_host_out_stream_pipe_setup_fsm (
      .i_clk(clk), .i_sys_rst(rst), .i_ep_config(cfg), .i_ep_halt_req(halt),
      .i_move_enable(men), .i_sw_post(post), .i_sw_stream(sstr), .i_sw_multi_pkt(smulti),
      .o_query_valid(qv), .o_query_stream(qs), .i_query_has_data(has),
      .i_query_multi_pkt(qmulti), .i_rx_nrdy(nrdy), .i_rx_erdy(erdy),
      .i_rx_ack_retry(aretry), .i_rx_dph_deferred(dfr), .i_rx_stream(rstr),
      .i_rx_nump(rnump), .i_move_done(done), .o_tx_dp(txdp), .o_tx_stream(txs),
      .o_tx_pp(txpp), .o_tx_zero_len(txz), .o_state(st), .o_current_stream(cur),
      .o_last_selected_stream(last), .o_pipe_halted(halted), .o_move_start(mstart));

   peer_stream_ep i_peer_stream_ep (
      .i_clk(clk), .i_tx_dp(txdp), .i_tx_zero_len(txz), .i_tx_stream(txs),
      .i_nbad(nbad), .i_defer(defer), .i_erdy_req(erq), .i_erdy_stream(estr),
      .o_nrdy(nrdy), .o_erdy(erdy), .o_ack_retry(aretry), .o_deferred(dfr),
      .o_stream(rstr), .o_nump(rnump));

   task automatic wrap_up;
      $display("mismatches %0d of %0d checks", err_count, n_tests);
      if (err_count == 0 && n_tests > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask

   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      n_tests++;
      if (got !== exp) begin
         err_count++;
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   task automatic do_post(input sid_t s, input logic m);
      @(negedge clk);
      post <= 1'b1;
      sstr <= s;
      smulti <= m;
      @(negedge clk);
      post <= 1'b0;
   endtask

   task automatic propose(input sid_t s);
      @(negedge clk);
      erq <= 1'b1;
      estr <= s;
      @(negedge clk);
      erq <= 1'b0;
   endtask

   task automatic wait_tx;
      for (int i = 0; i < 20 && txdp !== 1'b1; i++) @(negedge clk);
      chk(txdp, 1'b1);
   endtask

   task automatic wait_st(input pipe_state_e s);
      for (int i = 0; i < 80 && st !== s; i++) @(negedge clk);
      chk(st, s);
   endtask

   task automatic mdone;
      @(negedge clk);
      done <= 1'b1;
      @(negedge clk);
      done <= 1'b0;
      wait_st(ST_IDLE);
   endtask

   task automatic t_prime;
      nbad <= 3'h2;
      do_post(16'h0005, 1'b0);
      wait_tx;
      chk(txs, `SID_PRIME);
      chk(txpp, 1'b0);
      chk(txz, 1'b1);
      chk(st, ST_PRIME);
      wait_st(ST_IDLE);
   endtask

   task automatic t_cross;
      nbad <= 3'h0;
      do_post(16'h0000, 1'b1);
      wait_tx;
      chk(txs, `SID_PRIME);
      propose(16'h0005);
      @(negedge clk);
      chk(st, ST_PRIME);
      wait_st(ST_IDLE);
   endtask

   task automatic t_accept;
      has <= 1'b1;
      qmulti <= 1'b1;
      propose(16'h0005);
      wait_st(ST_START);
      chk(last, 16'h0005);
      chk(qv, 1'b1);
      chk(qs, 16'h0005);
      wait_tx;
      chk(txs, 16'h0005);
      chk(txz, 1'b0);
      chk(mstart, 1'b1);
      chk(st, ST_MOVE_DATA);
      chk(cur, 16'h0005);
      mdone;
   endtask

   task automatic t_host_move;
      do_post(16'h0005, 1'b1);
      wait_tx;
      chk(txs, 16'h0005);
      chk(txpp, 1'b1);
      chk(cur, 16'h0005);
      chk(mstart, 1'b1);
      chk(st, ST_MOVE_DATA);
      mdone;
      do_post(16'h0005, 1'b0);
      wait_tx;
      chk(txpp, 1'b0);
      mdone;
      do_post(16'h0007, 1'b1);
      wait_tx;
      chk(txs, `SID_PRIME);
      wait_st(ST_IDLE);
      men <= 1'b0;
      do_post(16'h0005, 1'b1);
      wait_tx;
      chk(txs, `SID_PRIME);
      wait_st(ST_IDLE);
   endtask

   task automatic t_reject;
      has <= 1'b0;
      propose(16'h0009);
      wait_tx;
      chk(txs, `SID_NO_STREAM);
      chk(txz, 1'b1);
      chk(txpp, 1'b0);
      chk(st, ST_START_END);
      wait_st(ST_IDLE);
   endtask

   task automatic t_defer_halt;
      defer <= 1'b1;
      do_post(16'h0007, 1'b0);
      wait_st(ST_IDLE);
      defer <= 1'b0;
      nbad <= 3'h7;
      do_post(16'h0007, 1'b0);
      wait_st(ST_HALTED);
      chk(halted, 1'b1);
      halt <= 1'b1;
      @(negedge clk);
      halt <= 1'b0;
      @(negedge clk);
      chk(st, ST_DISABLED);
      chk(last, `SID_NO_STREAM);
      nbad <= 3'h0;
      do_post(16'h0007, 1'b0);
      wait_st(ST_IDLE);
      cfg <= 1'b1;
      @(negedge clk);
      cfg <= 1'b0;
      @(negedge clk);
      chk(st, ST_DISABLED);
   endtask

   initial begin
      #(25 * 6000);
      err_count++;
      wrap_up;
   end

   initial begin
      repeat (16) @(negedge clk);
      chk(st, ST_DISABLED);
      chk(last, `SID_NO_STREAM);
      rst <= 1'b0;
      t_prime;
      t_cross;
      t_accept;
      t_host_move;
      t_reject;
      t_defer_halt;
      wrap_up;
   end
endmodule

`default_nettype wire
